/* core/psec_config.sv */
// configuration bank: packet options, security options, extended event mask and flags
// assumes the host bytes arrive one per rx_valid pulse, synchronous to sys_clk
`timescale 1ns/1ps
module psec_config
  import psec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic [23:0] event_flag_set,
  input wire logic [7:0] legacy_event_mask,
  input wire logic command_line_n,
  input wire logic send_packet_request,
  input wire logic push_button_input,
  input wire logic key_copies_cleared,
  input wire logic new_key_button_action,
  input wire logic rx_packet_plaintext,
  output logic event_alert_line,
  output logic [7:0] packet_options_out,
  output logic [7:0] join_options_out,
  output logic send_trigger,
  output logic tx_flush,
  output logic plaintext_drop,
  output logic cts_is_status,
  output logic factory_restore
);
  localparam int PRESS_CYC = SHORT_PRESS_MS * MS_CYCLES;
  localparam int HOLD_CYC = RESTORE_HOLD_MS * MS_CYCLES;

  logic rst_s1_reg, rst_s2_reg;
  logic rst_n;
  psec_frame_t st_reg;
  logic [1:0] esc_cnt_reg;
  logic [7:0] code_reg;
  logic [7:0] pkt_reg, pkt_nv_reg, sec_reg, sec_nv_reg;
  logic [7:0] mask_reg [3];
  logic [7:0] mask_nv_reg [3];
  logic [23:0] flag_reg;
  logic [7:0] ans_q_reg [3];
  logic [1:0] ans_cnt_reg;
  logic cmd_d_reg;
  logic [31:0] btn_cnt_reg;
  logic [2:0] press_cnt_reg;
  logic btn_d_reg;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // byte-to-register index: 0..2 mask, 3 packet, 4 security
  function automatic logic [2:0] loc_index(input logic [7:0] loc);
    logic [2:0] idx;
    idx = 3'h7;
    case (loc & ~CODE_LOC_BIT)
      (LOC_MASK2 & ~CODE_LOC_BIT), (LOC_MASK2_NV & ~CODE_LOC_BIT): idx = 3'h0;
      (LOC_MASK1 & ~CODE_LOC_BIT), (LOC_MASK1_NV & ~CODE_LOC_BIT): idx = 3'h1;
      (LOC_MASK0 & ~CODE_LOC_BIT), (LOC_MASK0_NV & ~CODE_LOC_BIT): idx = 3'h2;
      (LOC_PKT & ~CODE_LOC_BIT), (LOC_PKT_NV & ~CODE_LOC_BIT): idx = 3'h3;
      (LOC_SEC & ~CODE_LOC_BIT), (LOC_SEC_NV & ~CODE_LOC_BIT): idx = 3'h4;
      default: idx = 3'h7;
    endcase
    return idx;
  endfunction

  // decode of the current command
  wire logic [7:0] loc_w = code_reg | CODE_LOC_BIT;
  wire logic nv_w = (loc_w[6] == 1'b0); // 0x8x saved copy, 0xDx volatile
  wire logic [2:0] idx_w = loc_index(code_reg);
  wire logic is_flag_w = (loc_w >= LOC_FLAG2) && (loc_w <= LOC_FLAG0);
  wire logic [1:0] flag_byte_w = 2'(loc_w - LOC_FLAG2); // 0 is byte 2
  wire logic [7:0] sec_cur_w = nv_w ? sec_nv_reg : sec_reg;
  wire logic [7:0] wr_w = rx_byte;
  // edit lock and role checks on a security write
  wire logic lock_nack_w = !sec_cur_w[SEC_EDIT_ALLOW] &&
    ((!sec_cur_w[SEC_KEY_SHARE] && wr_w[SEC_KEY_SHARE]) ||
     (!sec_cur_w[SEC_EDIT_ALLOW] && wr_w[SEC_EDIT_ALLOW]) ||
     (!sec_cur_w[SEC_PLAINTEXT] && wr_w[SEC_PLAINTEXT]));
  wire logic role_nack_w = sec_cur_w[SEC_NODE_ROLE] && !wr_w[SEC_NODE_ROLE] && !key_copies_cleared;
  wire logic wr_fire_w = rx_valid && (st_reg == FR_VAL);
  wire logic rd_fire_w = rx_valid && (st_reg == FR_BODY) && (esc_cnt_reg == 2'd2);
  wire logic wr_ok_w = wr_fire_w && (is_flag_w || (idx_w != 3'h7)) &&
    !((idx_w == 3'h4) && (lock_nack_w || role_nack_w));
  wire logic pkt_wr_w = wr_ok_w && !nv_w && (idx_w == 3'h3);
  wire logic sec_wr_w = wr_ok_w && (idx_w == 3'h4);
  wire logic [7:0] pkt_new_w = wr_w & ~PKT_RESERVED_MASK;
  wire logic [7:0] sec_new_w = wr_w | (8'h01 << SEC_RESERVED);

  // read value selection
  function automatic logic [7:0] rd_value(input logic [2:0] idx, input logic nv,
      input logic [7:0] p, input logic [7:0] pn, input logic [7:0] s, input logic [7:0] sn,
      input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] m2,
      input logic [7:0] n0, input logic [7:0] n1, input logic [7:0] n2);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      3'h0: v = nv ? n0 : m0;
      3'h1: v = nv ? n1 : m1;
      3'h2: v = nv ? n2 : m2;
      3'h3: v = nv ? pn : p;
      3'h4: v = nv ? sn : s;
      default: v = 8'h00;
    endcase
    return v;
  endfunction
  // read value for the code byte arriving now, flags included
  wire logic [7:0] rd_loc_w = rx_byte | CODE_LOC_BIT;
  wire logic rd_flag_w = (rd_loc_w >= LOC_FLAG2) && (rd_loc_w <= LOC_FLAG0);
  wire logic [1:0] rd_fbyte_w = 2'(rd_loc_w - LOC_FLAG2); // 0 is byte 2
  wire logic [7:0] rd_w = rd_flag_w ? flag_reg[8'(23 - 8 * rd_fbyte_w) -: 8] :
    rd_value(loc_index(rx_byte), !rx_byte[6], pkt_reg, pkt_nv_reg, sec_reg, sec_nv_reg,
      mask_reg[0], mask_reg[1], mask_reg[2], mask_nv_reg[0], mask_nv_reg[1], mask_nv_reg[2]);

  // frame parser: header, size, escapes, code, value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= FR_HDR;
      esc_cnt_reg <= 2'd0;
      code_reg <= 8'h00;
    end else if (rx_valid) begin
      case (st_reg)
        FR_HDR: begin
          if (rx_byte == FRAME_HEADER) st_reg <= FR_SIZE;
          esc_cnt_reg <= 2'd0;
        end
        FR_SIZE: st_reg <= FR_BODY;
        FR_BODY: begin
          if (rx_byte == FRAME_ESCAPE && esc_cnt_reg != 2'd2) begin
            esc_cnt_reg <= esc_cnt_reg + 2'd1;
          end else if (esc_cnt_reg == 2'd1) begin
            code_reg <= rx_byte; // one escape: write frame
            st_reg <= FR_VAL;
          end else begin
            code_reg <= rx_byte; // two escapes: read frame
            st_reg <= FR_HDR;
          end
        end
        FR_VAL: st_reg <= FR_HDR;
        default: st_reg <= FR_HDR;
      endcase
    end
  end

  // answer queue: ack, location, value for a read, or a single ack or nack for a write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ans_cnt_reg <= 2'd0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      for (int i = 0; i < 3; i++) ans_q_reg[i] <= 8'h00;
    end else if (rd_fire_w) begin
      ans_q_reg[0] <= FRAME_ACK;
      ans_q_reg[1] <= rx_byte | CODE_LOC_BIT;
      ans_q_reg[2] <= rd_w;
      ans_cnt_reg <= 2'd3;
      tx_valid <= 1'b0;
    end else if (wr_fire_w) begin
      ans_q_reg[0] <= wr_ok_w ? FRAME_ACK : FRAME_NACK;
      ans_cnt_reg <= 2'd1;
      tx_valid <= 1'b0;
    end else if (ans_cnt_reg != 2'd0) begin
      tx_valid <= 1'b1;
      tx_byte <= ans_q_reg[0];
      ans_q_reg[0] <= ans_q_reg[1];
      ans_q_reg[1] <= ans_q_reg[2];
      ans_cnt_reg <= ans_cnt_reg - 2'd1;
    end else begin
      tx_valid <= 1'b0;
    end
  end

  // packet and security registers, volatile and saved copies
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_reg <= PKT_RESET;
      pkt_nv_reg <= PKT_RESET;
      sec_reg <= SEC_RESET;
      sec_nv_reg <= SEC_RESET;
    end else if (factory_restore) begin
      pkt_reg <= PKT_RESET;
      pkt_nv_reg <= PKT_RESET;
      sec_reg <= SEC_RESET; // restore lifts the edit lock
      sec_nv_reg <= SEC_RESET;
    end else begin
      if (wr_ok_w && nv_w && idx_w == 3'h3) pkt_nv_reg <= pkt_new_w;
      if (pkt_wr_w) pkt_reg <= pkt_new_w;
      if (sec_wr_w && nv_w) sec_nv_reg <= sec_new_w;
      if (sec_wr_w && !nv_w) sec_reg <= sec_new_w;
      if (new_key_button_action) begin
        sec_reg[SEC_NODE_ROLE] <= 1'b0;
        sec_nv_reg[SEC_NODE_ROLE] <= 1'b0;
      end
    end
  end

  // extended mask bytes, index 0 is byte 2
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_mask
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          mask_reg[g] <= MASK_RESET;
          mask_nv_reg[g] <= MASK_RESET;
        end else if (wr_ok_w && idx_w == 3'(g)) begin
          if (nv_w) mask_nv_reg[g] <= wr_w;
          else mask_reg[g] <= wr_w;
        end
      end
    end
  endgenerate

  // flags: writes AND in, new events win over the clear
  wire logic [23:0] flag_and_w = {(flag_byte_w == 2'd0) ? wr_w : 8'hFF,
    (flag_byte_w == 2'd1) ? wr_w : 8'hFF, (flag_byte_w == 2'd2) ? wr_w : 8'hFF};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) flag_reg <= 24'h000000;
    else if (wr_ok_w && is_flag_w) flag_reg <= (flag_reg & flag_and_w) | event_flag_set;
    else flag_reg <= flag_reg | event_flag_set;
  end

  // alert line from flags, mask and legacy mask every cycle
  wire logic alert_w = ((flag_reg & {mask_reg[0], mask_reg[1], mask_reg[2]}) != 24'h000000)
    && (legacy_event_mask == 8'h00);

  // send trigger: request or falling command line; explicit flag change by a volatile packet write flushes
  wire logic cmd_fall_w = cmd_d_reg && !command_line_n && pkt_reg[PKT_SEND_CMDLOW];
  wire logic flush_w = pkt_wr_w && (pkt_new_w[PKT_SEND_EXPL] != pkt_reg[PKT_SEND_EXPL]);

  // button restore: count short presses, then a long hold
  wire logic btn_rel_w = btn_d_reg && !push_button_input;
  wire logic restore_w = sec_reg[SEC_BTN_RESTORE] && push_button_input &&
    press_cnt_reg == 3'(RESTORE_PRESSES) && btn_cnt_reg == 32'(HOLD_CYC);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_cnt_reg <= 32'd0;
      press_cnt_reg <= 3'd0;
      btn_d_reg <= 1'b0;
      cmd_d_reg <= 1'b1;
    end else begin
      btn_d_reg <= push_button_input;
      cmd_d_reg <= command_line_n;
      if (push_button_input) btn_cnt_reg <= btn_cnt_reg + 32'd1;
      else if (btn_rel_w || btn_cnt_reg > 32'(PRESS_CYC)) btn_cnt_reg <= 32'd0;
      if (restore_w) press_cnt_reg <= 3'd0;
      else if (btn_rel_w) begin
        if (btn_cnt_reg <= 32'(PRESS_CYC) && press_cnt_reg < 3'(RESTORE_PRESSES))
          press_cnt_reg <= press_cnt_reg + 3'd1;
        else press_cnt_reg <= 3'd0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_alert_line <= 1'b0;
      packet_options_out <= PKT_RESET;
      join_options_out <= SEC_RESET;
      send_trigger <= 1'b0;
      tx_flush <= 1'b0;
      plaintext_drop <= 1'b0;
      cts_is_status <= 1'b0;
      factory_restore <= 1'b0;
    end else begin
      event_alert_line <= alert_w;
      packet_options_out <= pkt_reg;
      join_options_out <= sec_nv_reg;
      send_trigger <= send_packet_request || cmd_fall_w;
      tx_flush <= flush_w;
      plaintext_drop <= rx_packet_plaintext && !sec_reg[SEC_PLAINTEXT];
      cts_is_status <= pkt_reg[PKT_CTS_STATUS];
      factory_restore <= restore_w;
    end
  end
endmodule // psec_config

/* core/psec_pkg.sv */
// package for the packet, security and event-mask configuration bank
// assumes a byte-wide command/answer port in front of the bank, framing parsed inside the bank
package psec_pkg;
  // frame bytes
  localparam logic [7:0] FRAME_HEADER = 8'hFF;
  localparam logic [7:0] FRAME_ESCAPE = 8'hFE;
  localparam logic [7:0] FRAME_ACK = 8'h06;
  localparam logic [7:0] FRAME_NACK = 8'h15;
  localparam logic [7:0] FRAME_SIZE = 8'h03;
  // register locations
  localparam logic [7:0] LOC_MASK2_NV = 8'h80;
  localparam logic [7:0] LOC_MASK1_NV = 8'h81;
  localparam logic [7:0] LOC_MASK0_NV = 8'h82;
  localparam logic [7:0] LOC_PKT_NV = 8'h83;
  localparam logic [7:0] LOC_SEC_NV = 8'h84;
  localparam logic [7:0] LOC_MASK2 = 8'hD0;
  localparam logic [7:0] LOC_MASK1 = 8'hD1;
  localparam logic [7:0] LOC_MASK0 = 8'hD2;
  localparam logic [7:0] LOC_PKT = 8'hD3;
  localparam logic [7:0] LOC_SEC = 8'hD4;
  localparam logic [7:0] LOC_FLAG2 = 8'hCD;
  localparam logic [7:0] LOC_FLAG1 = 8'hCE;
  localparam logic [7:0] LOC_FLAG0 = 8'hCF;
  // address code = location with bit 7 cleared
  localparam logic [7:0] CODE_LOC_BIT = 8'h80;
  // packet option fields
  localparam int PKT_SEND_EXPL = 0;
  localparam int PKT_SEND_CMDLOW = 1;
  localparam int PKT_RECV_EXPL = 2;
  localparam int PKT_CTS_STATUS = 3;
  localparam logic [7:0] PKT_RESERVED_MASK = 8'hF0;
  // security option fields
  localparam int SEC_BTN_RESTORE = 0;
  localparam int SEC_KEY_SHARE = 1;
  localparam int SEC_KEY_CHANGE = 2;
  localparam int SEC_ADDR_CHANGE = 3;
  localparam int SEC_NODE_ROLE = 4;
  localparam int SEC_PLAINTEXT = 5;
  localparam int SEC_RESERVED = 6;
  localparam int SEC_EDIT_ALLOW = 7;
  // reset values
  localparam logic [7:0] PKT_RESET = 8'h00;
  localparam logic [7:0] SEC_RESET = 8'hFF;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // timing
  localparam int CLK_HZ = 100000000;
  localparam int RESTORE_HOLD_MS = 3000;
  localparam int SHORT_PRESS_MS = 1000;
  localparam int RESTORE_PRESSES = 4;
  localparam int MS_CYCLES = CLK_HZ / 1000;

  // one command as handed over by the byte framer
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] data;
  } psec_cmd_t;

  // one answer back toward the host
  typedef struct packed {
    logic valid;
    logic [7:0] status;
    logic [7:0] loc;
    logic [7:0] data;
  } psec_ans_t;

  typedef enum logic [3:0] {
    FR_HDR = 4'h1,
    FR_SIZE = 4'h2,
    FR_BODY = 4'h4,
    FR_VAL = 4'h8
  } psec_frame_t;
endpackage

/* tb/psec_config_properties.sv */
// checker for the configuration bank, bound to its top ports
// assumes one clock domain and the active-low reset of the bank
`timescale 1ns/1ps
module psec_config_checker
  import psec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic send_packet_request,
  input wire logic command_line_n,
  input wire logic [7:0] legacy_event_mask,
  input wire logic rx_packet_plaintext,
  input wire logic event_alert_line,
  input wire logic [7:0] packet_options_out,
  input wire logic [7:0] join_options_out,
  input wire logic send_trigger,
  input wire logic tx_flush,
  input wire logic plaintext_drop,
  input wire logic cts_is_status,
  input wire logic push_button_input,
  input wire logic factory_restore
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // option bytes keep their fixed bits
  AST_PKT_RESERVED: assert property (packet_options_out[7:4] == 4'h0)
    else $error("reserved packet bits set");
  AST_SEC_RESERVED: assert property (join_options_out[SEC_RESERVED])
    else $error("reserved security bit clear");
  // send triggers and flush
  AST_SEND_REQUEST: assert property (send_packet_request |-> ##[1:2] send_trigger)
    else $error("send request not followed by trigger");
  AST_CMD_LOW: assert property (packet_options_out[PKT_SEND_CMDLOW] && $fell(command_line_n) |-> ##[1:3] send_trigger)
    else $error("command line fall did not trigger");
  AST_FLUSH: assert property ($changed(packet_options_out[PKT_SEND_EXPL]) |-> $past(tx_flush))
    else $error("send mode change without flush");
  // alert and receive side
  AST_ALERT_LEGACY: assert property ($past(legacy_event_mask) != 8'h00 |-> !event_alert_line)
    else $error("alert while legacy mask nonzero");
  AST_DROP_CAUSE: assert property (plaintext_drop |-> $past(rx_packet_plaintext))
    else $error("drop without plaintext packet");
  AST_CTS_MODE: assert property ($stable(packet_options_out) |-> cts_is_status == packet_options_out[PKT_CTS_STATUS])
    else $error("cts mode differs from option bit");
  // restore only while the button is held
  AST_RESTORE_CAUSE: assert property (factory_restore |-> $past(push_button_input))
    else $error("restore without button held");
endmodule // psec_config_checker
bind psec_config psec_config_checker u_psec_config_checker (.sys_clk, .resetn, .send_packet_request,
  .command_line_n, .legacy_event_mask, .rx_packet_plaintext, .event_alert_line, .packet_options_out,
  .join_options_out, .send_trigger, .tx_flush, .plaintext_drop, .cts_is_status, .push_button_input,
  .factory_restore);

/* tb/psec_host_model.sv */
// host side model: sends command frames, collects answer bytes
// assumes calls start just after a rising edge of sys_clk
`timescale 1ns/1ps
module psec_host_model
  import psec_pkg::*;
(
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte
);
  logic [7:0] ans_q[$];
  initial begin
    rx_valid = 1'h0;
    rx_byte = 8'h00;
  end
  // answer bytes as they pulse
  always @(posedge sys_clk) if (tx_valid === 1'h1) ans_q.push_back(tx_byte);
  // one byte per cycle, valid held between bytes
  task automatic put(input logic [7:0] b);
    rx_valid = 1'h1;
    rx_byte = b;
    @(posedge sys_clk);
    #1;
  endtask
  // read has two escapes, write one escape and a value; fixed bits kept for LOC_PKT and LOC_SEC only
  task automatic frame(input logic wr, input logic [7:0] loc, input logic [7:0] val);
    logic [7:0] d;
    d = val;
    if ((loc | CODE_LOC_BIT) == LOC_PKT) d = val & ~PKT_RESERVED_MASK;
    if ((loc | CODE_LOC_BIT) == LOC_SEC) d[SEC_RESERVED] = 1'h1;
    ans_q.delete();
    put(FRAME_HEADER);
    put(FRAME_SIZE);
    put(FRAME_ESCAPE);
    if (!wr) put(FRAME_ESCAPE);
    put(loc & ~CODE_LOC_BIT);
    if (wr) put(d);
    rx_valid = 1'h0;
    rx_byte = ~rx_byte; // released line shows no stale byte
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
endmodule // psec_host_model

/* tb/psec_config_tb.sv */
// self-checking bench for the configuration bank
// assumes the host model on the byte port and the bound checker
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module psec_config_tb
  import psec_pkg::*;
;
  logic sys_clk = 1'h0, resetn = 1'h0, command_line_n = 1'h1, send_packet_request = 1'h0;
  logic key_copies_cleared = 1'h0, new_key_button_action = 1'h0, rx_packet_plaintext = 1'h0;
  logic [23:0] event_flag_set = 24'h000000;
  logic [7:0] legacy_event_mask = 8'h00, rx_byte, tx_byte, packet_options_out, join_options_out, v, sec, a;
  logic rx_valid, tx_valid, event_alert_line, send_trigger, tx_flush, plaintext_drop, cts_is_status;
  logic push_button_input = 1'h0, factory_restore;
  int rest_n = 0;
  logic [7:0] locs [10] = '{LOC_MASK2_NV, LOC_MASK1_NV, LOC_MASK0_NV, LOC_PKT_NV, LOC_SEC_NV,
    LOC_MASK2, LOC_MASK1, LOC_MASK0, LOC_PKT, LOC_SEC};
  int mismatches = 0, num_checks = 0, trig_n = 0, flush_n = 0, drop_n = 0, t0, f0;

  psec_config u_psec_config (.sys_clk, .resetn, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .event_flag_set,
    .legacy_event_mask, .command_line_n, .send_packet_request, .push_button_input, .key_copies_cleared,
    .new_key_button_action, .rx_packet_plaintext, .event_alert_line, .packet_options_out, .join_options_out,
    .send_trigger, .tx_flush, .plaintext_drop, .cts_is_status, .factory_restore);
  psec_host_model u_psec_host_model (.sys_clk, .rx_valid, .rx_byte, .tx_valid, .tx_byte);

  always #5 sys_clk = ~sys_clk;
  // counts of one-cycle output pulses
  always @(posedge sys_clk) begin
    if (send_trigger === 1'h1) trig_n++;
    if (tx_flush === 1'h1) flush_n++;
    if (plaintext_drop === 1'h1) drop_n++;
    if (factory_restore === 1'h1) rest_n++;
  end

  function automatic logic [7:0] rst_val(input logic [7:0] l);
    return (l[3:0] == 4'h4) ? SEC_RESET : (l[3:0] == 4'h3) ? PKT_RESET : MASK_RESET;
  endfunction
  // answer to a security write: lock and role change refusals
  function automatic logic [7:0] sec_ans(input logic [7:0] o, input logic [7:0] n, input logic kc);
    logic [7:0] up;
    up = n & ~o;
    if (!o[SEC_EDIT_ALLOW] && (up[SEC_KEY_SHARE] || up[SEC_EDIT_ALLOW] || up[SEC_PLAINTEXT])) return FRAME_NACK;
    if (o[SEC_NODE_ROLE] && !n[SEC_NODE_ROLE] && !kc) return FRAME_NACK;
    return FRAME_ACK;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rchk(input logic [7:0] loc, input logic [7:0] exp);
    u_psec_host_model.frame(1'h0, loc, 8'h00);
    `CHK(u_psec_host_model.ans_q.size(), 3)
    `CHK(u_psec_host_model.ans_q[0], FRAME_ACK)
    `CHK(u_psec_host_model.ans_q[1], loc)
    `CHK(u_psec_host_model.ans_q[2], exp)
  endtask
  task automatic wr(input logic [7:0] loc, input logic [7:0] val, input logic [7:0] ans);
    u_psec_host_model.frame(1'h1, loc, val);
    `CHK(u_psec_host_model.ans_q[0], ans)
  endtask
  task automatic req();
    send_packet_request = 1'h1;
    tick(1);
    send_packet_request = 1'h0;
    tick(3);
  endtask
  task automatic cmd_fall();
    command_line_n = 1'h0;
    tick(4);
    command_line_n = 1'h1;
    tick(2);
  endtask
  task automatic plain();
    rx_packet_plaintext = 1'h1;
    tick(1);
    rx_packet_plaintext = 1'h0;
    tick(3);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hF7017E2F));
    tick(16);
    resetn = 1'h1;
    tick(3);
    foreach (locs[i]) rchk(locs[i], rst_val(locs[i]));
    wr(LOC_SEC_NV, 8'hFB, FRAME_ACK);
    `CHK(join_options_out, 8'hFB)
    for (int i = 0; i < 9; i++) if (i != 4) begin
      v = 8'($urandom);
      wr(locs[i], v, FRAME_ACK);
      rchk(locs[i], v & ((i % 5 == 3) ? 8'h0F : 8'hFF));
    end
    `CHK(packet_options_out, v & 8'h0F)
    wr(8'hFF, 8'h5A, FRAME_NACK);
    rchk(8'hFF, 8'h00);
    // send triggers in both modes and flush on mode change
    wr(LOC_PKT, 8'h00, FRAME_ACK);
    t0 = trig_n;
    f0 = flush_n;
    req();
    wr(LOC_PKT, 8'h03, FRAME_ACK);
    cmd_fall();
    req();
    wr(LOC_PKT, 8'h09, FRAME_ACK);
    `CHK(cts_is_status, 1'h1)
    cmd_fall();
    wr(LOC_PKT, 8'h00, FRAME_ACK);
    `CHK(trig_n - t0, 3)
    `CHK(flush_n - f0, 2)
    // alert from flag and mask, legacy override, and-clear of flags
    for (int i = 5; i < 8; i++) wr(locs[i], 8'h00, FRAME_ACK);
    event_flag_set = 24'h000001;
    tick(1);
    event_flag_set = 24'h000000;
    wr(LOC_MASK2, 8'h01, FRAME_ACK);
    `CHK(event_alert_line, 1'h0)
    wr(LOC_MASK0, 8'h01, FRAME_ACK);
    `CHK(event_alert_line, 1'h1)
    rchk(LOC_FLAG0, 8'h01);
    rchk(LOC_FLAG0, 8'h01);
    legacy_event_mask = 8'($urandom_range(255, 1));
    tick(2);
    `CHK(event_alert_line, 1'h0)
    legacy_event_mask = 8'h00;
    tick(2);
    `CHK(event_alert_line, 1'h1)
    wr(LOC_FLAG0, 8'hFE, FRAME_ACK);
    `CHK(event_alert_line, 1'h0)
    rchk(LOC_FLAG0, 8'h00);
    // plaintext handling and security write refusals
    t0 = drop_n;
    plain();
    wr(LOC_SEC, 8'hEF, FRAME_NACK);
    wr(LOC_SEC, 8'hDF, FRAME_ACK);
    plain();
    `CHK(drop_n - t0, 1)
    sec = 8'hDF;
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom) | 8'h40;
      key_copies_cleared = 1'($urandom);
      a = sec_ans(sec, v, key_copies_cleared);
      wr(LOC_SEC, v, a);
      if (a == FRAME_ACK) sec = v;
      rchk(LOC_SEC, sec);
    end
    new_key_button_action = 1'h1;
    tick(1);
    new_key_button_action = 1'h0;
    sec[SEC_NODE_ROLE] = 1'h0;
    rchk(LOC_SEC, sec);
    // short presses alone never restore; the long hold lies far beyond this run
    for (int i = 0; i < 5; i++) begin
      push_button_input = 1'h1;
      tick(3);
      push_button_input = 1'h0;
      tick(3);
    end
    `CHK(rest_n, 0)
    rchk(LOC_SEC, sec);
    conclude();
  end
  // cut a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule // psec_config_tb
